// File: rtl/nvs_map.svh
// Purpose: Constants of the two-wire nonvolatile memory slave port.
// Assumes: Included by bare name from the port module; the package does not include it.
// Notes: Definitions only; the types live in nvs_pkg.
`ifndef NVS_MAP_SVH
`define NVS_MAP_SVH
// Device type nibble of a memory access, bits 7 to 4 of the first byte.
`define NVS_DEV_TYPE 4'hA
// Device type nibble that opens the identification word; read only.
`define NVS_ID_TYPE 4'hF
// Upper five bits of the high-speed master code.
`define NVS_HS_CODE 5'h01
// Bit counter value during the ninth (acknowledge) clock.
`define NVS_BIT_ACK 4'h8
// Bit counter value of the last data bit of a byte.
`define NVS_BIT_LAST 4'h7
// Number of bytes in the identification word.
`define NVS_ID_BYTES 2'h3
// Default address width: 32,768 locations of eight bits.
`define NVS_ADDR_W 15
`endif

// File: rtl/nvs_pkg.sv
// Purpose: Types shared by the two-wire nonvolatile memory slave port.
// Assumes: Nothing beyond the constants header.
// Notes: States are one-hot with codes written out.
package nvs_pkg;
    // Pins that are sampled from outside the clock domain, kept together.
    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
        logic [2:0] sel;
    } nvs_pins_t;
    // Bus conditions found by the sampler, each a one-cycle pulse.
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } nvs_ev_t;
    // Byte-level phase of a transaction.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DEV = 7'h02,
        ST_ADRHI = 7'h04,
        ST_ADRLO = 7'h08,
        ST_WR = 7'h10,
        ST_RD = 7'h20,
        ST_ID = 7'h40
    } nvs_state_t;
endpackage : nvs_pkg

// File: rtl/nvs_slave_port.sv
// Purpose: Two-wire serial slave port of a byte-wide nonvolatile memory.
// Assumes: clk at 25 MHz oversamples SCL; the master supplies SCL.
// Notes: The data line is open drain: sda_o is held low, sda_oe drives.
// What this block does
// R1: Array of 32,768 bytes, byte-wide accesses only.
// R2: Each received data byte commits at once.
// R3: Ready for next transaction, never busy.
// R4: Read-only identification word, writes cannot alter.
// R5: Respond only when select bits match straps.
// R6: Unconnected select straps read as zero.
// R7: Data line driven low or released only.
// R8: Drive after SCL falls, sample on rise.
// R9: Write-protect strap high blocks all writes.
// R10: Unconnected write-protect strap means writes enabled.
// R11: Standard and fast rates; faster only high-speed.
// R12: First byte: type 1010, select, direction.
// R13: 15-bit address, increment before ack, wraps.
// R14: STOP or START aborts; START awaits address.
// R15: Master code enters high-speed until STOP.
// R16: Receiver acks ninth clock; master nack ends read.
// R17: Protected writes still ack and advance address.
`timescale 1ns/1ps
`include "nvs_map.svh"
module nvs_slave_port #(
    parameter int ADDR_W = `NVS_ADDR_W,
    // Identification word, manufacturer/density/revision; value is arbitrary.
    parameter logic [23:0] ID_WORD = 24'h12_3456
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [2:0] device_select_straps,
    input wire logic wp,
    output logic hs_mode
);
    // The address latch cannot exceed the two address bytes minus the don't-care bit.
    if (ADDR_W < 1 || ADDR_W > 15) begin : g_bad_width
        $error("ADDR_W must be 1 to 15");
    end

    // Raw pins gathered; the pads pull select and protect low when open. R6 R10
    nvs_pkg::nvs_pins_t pins_raw;
    // First synchroniser stage, read only by the second.
    nvs_pkg::nvs_pins_t pins_m;
    // Second stage, the copy logic reads together with its delayed value pins_q.
    nvs_pkg::nvs_pins_t pins_s;
    // Previous second-stage value, for edge and condition detection.
    nvs_pkg::nvs_pins_t pins_q;
    // Conditions decoded from the synchronised pins.
    nvs_pkg::nvs_ev_t ev;
    // Byte phase and the phase that follows the current acknowledge.
    nvs_pkg::nvs_state_t state;
    nvs_pkg::nvs_state_t after_ack;
    // Bits seen in the current byte, 8 during the acknowledge clock.
    logic [3:0] bitcnt;
    // Incoming shift register and outgoing byte.
    logic [7:0] shreg;
    logic [7:0] obyte;
    // Address latch and the high address byte held until the low one arrives.
    logic [ADDR_W-1:0] addr;
    logic [6:0] addr_hi;
    // Index of the next identification byte.
    logic [1:0] id_idx;
    // SCL has risen in this bit since the last fall, START or STOP. The fall
    // that follows a START carries no bit, so it must not move the counter.
    logic bit_rose;
    // The storage itself. R1
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    assign pins_raw = '{scl: scl, sda: sda_i, wp: wp, sel: device_select_straps};

    // Two flip-flops on every pin before any logic looks at it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_m <= '1;
            pins_s <= '1;
            pins_q <= '1;
        end else begin
            pins_m <= pins_raw;
            pins_s <= pins_m;
            pins_q <= pins_s;
        end
    end

    // START and STOP are SDA edges while SCL stays high. Oversampling at
    // 25 MHz serves 100 kHz and 400 kHz; 3.4 MHz needs a faster clk. R11
    assign ev.start = pins_s.scl && pins_q.scl && pins_q.sda && !pins_s.sda;
    assign ev.stop = pins_s.scl && pins_q.scl && !pins_q.sda && pins_s.sda;
    assign ev.rise = pins_s.scl && !pins_q.scl;
    assign ev.fall = !pins_s.scl && pins_q.scl;

    // Named decode of the byte and bit position.
    wire active = (state != nvs_pkg::ST_IDLE);
    wire is_tx = (state == nvs_pkg::ST_RD) || (state == nvs_pkg::ST_ID);
    // A fall counts only once a rise has been seen in the same bit.
    wire bit_done = ev.fall && active && bit_rose;
    wire bit_fall = bit_done && (bitcnt < `NVS_BIT_LAST);
    wire byte_end = bit_done && (bitcnt == `NVS_BIT_LAST);
    wire ack_end = bit_done && (bitcnt == `NVS_BIT_ACK);
    wire ack_rise = ev.rise && active && (bitcnt == `NVS_BIT_ACK);
    wire sel_ok = (shreg[3:1] == pins_s.sel); // R5
    wire hit_mem = (shreg[7:4] == `NVS_DEV_TYPE) && sel_ok; // R12
    wire hit_id = (shreg[7:4] == `NVS_ID_TYPE) && sel_ok && shreg[0];
    wire hs_code = (shreg[7:3] == `NVS_HS_CODE);
    wire in_dev = (state == nvs_pkg::ST_DEV);
    // The device acks a matching address and every address or data byte,
    // protected or not, since protection only keeps the array unchanged. R17
    wire ack_now = in_dev ? (hit_mem || hit_id) : !is_tx;
    // A write commits on the falling edge that ends its eighth bit. R2 R9
    wire mem_we = byte_end && (state == nvs_pkg::ST_WR) && !pins_s.wp;
    // Address advances just before the acknowledge of each data byte. R13
    wire addr_step = byte_end && ((state == nvs_pkg::ST_WR) || (state == nvs_pkg::ST_RD));
    // Byte to send once the acknowledge clock ends.
    wire [7:0] id_byte = ID_WORD[8*(2-id_idx) +: 8];
    wire [7:0] load = (after_ack == nvs_pkg::ST_ID) ? id_byte : mem[addr];

    // Phase that follows the byte now ending.
    nvs_pkg::nvs_state_t next_after;
    always_comb begin
        case (state)
            nvs_pkg::ST_DEV: begin
                if (hit_mem) begin
                    next_after = shreg[0] ? nvs_pkg::ST_RD : nvs_pkg::ST_ADRHI;
                end else if (hit_id) begin
                    next_after = nvs_pkg::ST_ID;
                end else begin
                    next_after = nvs_pkg::ST_IDLE;
                end
            end
            nvs_pkg::ST_ADRHI: next_after = nvs_pkg::ST_ADRLO;
            nvs_pkg::ST_ADRLO: next_after = nvs_pkg::ST_WR;
            nvs_pkg::ST_WR: next_after = nvs_pkg::ST_WR;
            nvs_pkg::ST_RD: next_after = nvs_pkg::ST_RD;
            nvs_pkg::ST_ID: next_after = nvs_pkg::ST_ID;
            default: next_after = nvs_pkg::ST_IDLE;
        endcase
    end

    // Sequencer. STOP and START win over everything and abort at once; no
    // write ever leaves a busy phase behind, so a new START is served. R3 R14
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= nvs_pkg::ST_IDLE;
            after_ack <= nvs_pkg::ST_IDLE;
            bitcnt <= 4'h0;
        end else if (ev.stop) begin
            state <= nvs_pkg::ST_IDLE; // R14
        end else if (ev.start) begin
            state <= nvs_pkg::ST_DEV; // R14
            bitcnt <= 4'h0;
        end else if (ack_rise && is_tx && pins_s.sda) begin
            state <= nvs_pkg::ST_IDLE; // R16
        end else if (bit_fall) begin
            bitcnt <= bitcnt + 4'h1;
        end else if (byte_end) begin
            bitcnt <= `NVS_BIT_ACK;
            after_ack <= next_after;
        end else if (ack_end) begin
            bitcnt <= 4'h0;
            state <= after_ack;
        end
    end

    // Incoming bits are taken on rising SCL only. R8
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= 8'h00;
        end else if (ev.rise && active && (bitcnt < `NVS_BIT_ACK)) begin
            shreg <= {shreg[6:0], pins_s.sda}; // R8
        end
    end

    // Rise tracker. Without it the SCL fall just after a START would be
    // taken as the end of a bit and the address byte would lose a bit.
    // A START or STOP always leaves the next fall ignored. R8
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_rose <= 1'b0;
        end else if (ev.start || ev.stop || ev.fall) begin
            bit_rose <= 1'b0;
        end else if (ev.rise) begin
            bit_rose <= 1'b1;
        end
    end

    // The open-drain driver changes only after a falling SCL, or on an
    // abort, so it never makes a false START or STOP of its own. R7 R8
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            obyte <= 8'h00;
        end else begin
            sda_o <= 1'b0; // R7
            if (ev.stop || ev.start) begin
                sda_oe <= 1'b0;
            end else if (bit_fall && is_tx) begin
                obyte <= {obyte[6:0], 1'b0};
                sda_oe <= !obyte[6]; // R8
            end else if (byte_end) begin
                sda_oe <= ack_now; // R16
            end else if (ack_end) begin
                obyte <= load;
                sda_oe <= ((after_ack == nvs_pkg::ST_RD) || (after_ack == nvs_pkg::ST_ID))
                    && !load[7];
            end
        end
    end

    // Address latch: two bytes, top bit ignored, wrap at the last address. R13
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr <= '0;
            addr_hi <= 7'h00;
        end else if (byte_end && (state == nvs_pkg::ST_ADRHI)) begin
            addr_hi <= shreg[6:0];
        end else if (byte_end && (state == nvs_pkg::ST_ADRLO)) begin
            addr <= ADDR_W'({addr_hi, shreg});
        end else if (addr_step) begin
            addr <= addr + 1'b1; // R13
        end
    end

    // Identification bytes run in order and restart at a new address. R4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_idx <= 2'h0;
        end else if (ev.start) begin
            id_idx <= 2'h0;
        end else if (byte_end && (state == nvs_pkg::ST_ID)) begin
            id_idx <= (id_idx == `NVS_ID_BYTES - 2'h1) ? 2'h0 : id_idx + 2'h1;
        end
    end

    // High-speed flag: set by the master code, cleared only by STOP. R15
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_mode <= 1'b0;
        end else if (ev.stop) begin
            hs_mode <= 1'b0;
        end else if (byte_end && in_dev && hs_code) begin
            hs_mode <= 1'b1; // R15
        end
    end

    // Array write port; the array holds no reset, as nonvolatile data would.
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[addr] <= shreg; // R2
        end
    end

    // Checks of the port's behaviour.
    logic [7:0] mem_before;
    assign mem_before = mem[addr];
    sequence s_wr_byte;
        byte_end && (state == nvs_pkg::ST_WR);
    endsequence
    sequence s_abort;
        ev.stop || ev.start;
    endsequence

    a_sda_low_only: assert property (@(posedge clk) disable iff (!rst_n) // R7
        sda_oe |-> !sda_o) else $error("data line driven high");
    a_write_commit: assert property (@(posedge clk) disable iff (!rst_n) // R2
        s_wr_byte and !pins_s.wp |=> mem[$past(addr)] == $past(shreg))
        else $error("byte not committed");
    a_wp_blocks: assert property (@(posedge clk) disable iff (!rst_n) // R9
        s_wr_byte and pins_s.wp |=> mem[$past(addr)] == $past(mem_before))
        else $error("protected byte changed");
    a_addr_step: assert property (@(posedge clk) disable iff (!rst_n) // R13
        s_wr_byte |=> addr == ADDR_W'($past(addr) + 1'b1))
        else $error("address did not advance");
    a_select_ack: assert property (@(posedge clk) disable iff (!rst_n) // R5
        byte_end && in_dev && !sel_ok |=> !sda_oe ##1 !sda_oe)
        else $error("acked foreign select");
    a_abort_idle: assert property (@(posedge clk) disable iff (!rst_n) // R14
        ev.stop |=> state == nvs_pkg::ST_IDLE && !sda_oe)
        else $error("stop did not abort");
    a_start_dev: assert property (@(posedge clk) disable iff (!rst_n) // R14
        ev.start && !ev.stop |=> state == nvs_pkg::ST_DEV && bitcnt == 4'h0)
        else $error("start did not rearm");
    a_drive_fall: assert property (@(posedge clk) disable iff (!rst_n) // R8
        $changed(sda_oe) |-> $past(ev.fall) || $past(ev.start) || $past(ev.stop))
        else $error("data changed off a falling edge");
    a_hs_hold: assert property (@(posedge clk) disable iff (!rst_n) // R15
        hs_mode && !ev.stop |=> hs_mode) else $error("high-speed lost early");
    a_id_readonly: assert property (@(posedge clk) disable iff (!rst_n) // R4
        byte_end && in_dev && (shreg[7:4] == `NVS_ID_TYPE) && !shreg[0] |=> !sda_oe)
        else $error("write to the id word acked");
    a_wp_ack: assert property (@(posedge clk) disable iff (!rst_n) // R17
        s_wr_byte ##0 (!ev.stop && !ev.start) |=> sda_oe)
        else $error("data byte not acked");
    a_abort_release: assert property (@(posedge clk) disable iff (!rst_n) // R14
        s_abort |=> !sda_oe) else $error("abort left the data line driven");
    a_rd_release: assert property (@(posedge clk) disable iff (!rst_n) // R16
        byte_end && is_tx |=> !sda_oe) else $error("data line held for master ack");
    a_fall_norise: assert property (@(posedge clk) disable iff (!rst_n) // R8
        ev.fall && !bit_rose |=> bitcnt == $past(bitcnt))
        else $error("fall without a rise moved the bit count");
endmodule : nvs_slave_port

// File: test/nvs_bus_master.sv
// Purpose: Behavioural two-wire bus master that drives the slave port.
// Assumes: clk is the bench clock; each SCL phase lasts four clk cycles.
// Notes: SDA is driven open drain; the bench resolves the wire.
`timescale 1ns/1ps
module nvs_bus_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    // Both lines rest released, so the bus stands high outside frames.
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // One bit: data moves only while SCL is low, and is read just before SCL falls.
    task automatic bit_x(input logic b, output logic r);
        repeat (2) @(posedge clk);
        sda_m <= b;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        r = sda;
        scl <= 1'b0;
    endtask : bit_x
    // START or repeated START: SDA falls while SCL is high.
    task automatic start_c();
        repeat (2) @(posedge clk);
        sda_m <= 1'b1;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_m <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask : start_c
    // STOP: SDA rises while SCL is high, then the bus idles.
    task automatic stop_c();
        repeat (2) @(posedge clk);
        sda_m <= 1'b0;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_m <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : stop_c
    // Sends a byte MSB first and releases SDA for the slave's acknowledge.
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : put_byte
    // Reads a byte; a missing acknowledge on the last byte frees the bus.
    task automatic get_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(~more, r);
    endtask : get_byte
endmodule : nvs_bus_master

// File: test/testbench.sv
// Purpose: Self-checking bench of the two-wire memory slave port.
// Assumes: The bus master model runs SCL at a 320 ns period.
// Notes: Scenarios share byte tasks; expectations come from the rules.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    // Identification word for the bench; the value is arbitrary.
    localparam logic [23:0] ID = 24'hA5C3_E1;
    logic clk;
    logic rst_n;
    logic wp;
    logic [2:0] sel;
    logic ack;
    logic [7:0] d;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    wire logic scl;
    wire logic sda_m;
    wire logic sda_oe;
    wire logic sda_o;
    wire logic hs_mode;
    wire logic sda;
    // Wired-AND with a pull-up: either party may only pull low.
    assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
    nvs_slave_port #(.ID_WORD(ID)) dut_u (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .device_select_straps(sel), .wp(wp),
        .hs_mode(hs_mode));
    nvs_bus_master m_u (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // The device must never drive the wire high while it is enabled.
    always @(posedge clk) begin
        if (sda_oe === 1'b1) `CHK(sda_o, 1'b0)
    end
    // A hang is cut short well beyond the expected run of about 4,000 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    // Selects the device for writing and loads a two-byte address.
    task automatic addr_wr(input logic [15:0] a);
        m_u.start_c();
        m_u.put_byte({4'hA, sel, 1'b0}, ack);
        `CHK(ack, 1'b1)
        m_u.put_byte(a[15:8], ack);
        `CHK(ack, 1'b1)
        m_u.put_byte(a[7:0], ack);
        `CHK(ack, 1'b1)
    endtask : addr_wr
    // Restarts as a reader at the current address and checks the acknowledge.
    task automatic rd_open();
        m_u.start_c();
        m_u.put_byte({4'hA, sel, 1'b1}, ack);
        `CHK(ack, 1'b1)
    endtask : rd_open
    task automatic wr_chk(input logic [7:0] v);
        m_u.put_byte(v, ack);
        `CHK(ack, 1'b1)
    endtask : wr_chk
    task automatic rd_chk(input logic [7:0] e, input logic more);
        m_u.get_byte(more, d);
        `CHK(d, e)
    endtask : rd_chk
    // Write two bytes, stop, reload the address, then read them back through a repeated START.
    task automatic t_write_read();
        addr_wr(16'h0123);
        wr_chk(8'h5A);
        wr_chk(8'hA5);
        m_u.stop_c();
        addr_wr(16'h0123);
        rd_open();
        rd_chk(8'h5A, 1'b1);
        rd_chk(8'hA5, 1'b0);
        m_u.stop_c();
    endtask : t_write_read
    // Every select value; only the strapped one answers, a foreign type never.
    task automatic t_select();
        for (int j = 0; j < 8; j++) begin
            m_u.start_c();
            m_u.put_byte({4'hA, 3'(j), 1'b0}, ack);
            `CHK(ack, (3'(j) == sel))
            m_u.stop_c();
        end
        m_u.start_c();
        m_u.put_byte({4'hB, sel, 1'b0}, ack);
        `CHK(ack, 1'b0)
        m_u.stop_c();
    endtask : t_select
    // Top address bit is ignored and the address wraps to zero.
    task automatic t_wrap();
        addr_wr(16'hFFFF);
        wr_chk(8'h11);
        wr_chk(8'h22);
        m_u.stop_c();
        addr_wr(16'h7FFF);
        rd_open();
        rd_chk(8'h11, 1'b1);
        rd_chk(8'h22, 1'b0);
        m_u.stop_c();
    endtask : t_wrap
    // Protected write is acknowledged and advances the address only.
    task automatic t_protect();
        @(posedge clk) wp <= 1'b1;
        addr_wr(16'h0123);
        wr_chk(8'hC3);
        m_u.stop_c();
        rd_open();
        rd_chk(8'hA5, 1'b0);
        m_u.stop_c();
        addr_wr(16'h0123);
        rd_open();
        rd_chk(8'h5A, 1'b0);
        m_u.stop_c();
        @(posedge clk) wp <= 1'b0;
    endtask : t_protect
    // Identification word reads in order and repeats; writing it is refused.
    task automatic t_ident();
        m_u.start_c();
        m_u.put_byte({4'hF, sel, 1'b1}, ack);
        `CHK(ack, 1'b1)
        rd_chk(ID[23:16], 1'b1);
        rd_chk(ID[15:8], 1'b1);
        rd_chk(ID[7:0], 1'b1);
        rd_chk(ID[23:16], 1'b0);
        m_u.stop_c();
        m_u.start_c();
        m_u.put_byte({4'hF, sel, 1'b0}, ack);
        `CHK(ack, 1'b0)
        m_u.stop_c();
    endtask : t_ident
    // Master code enters high-speed mode, which only STOP leaves.
    task automatic t_hs();
        m_u.start_c();
        m_u.put_byte(8'h09, ack);
        `CHK(ack, 1'b0)
        `CHK(hs_mode, 1'b1)
        m_u.stop_c();
        `CHK(hs_mode, 1'b0)
    endtask : t_hs
    // Reset for ten cycles, let the synchronisers fill, then run each scenario.
    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        sel = 3'h5;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_write_read();
        t_select();
        t_wrap();
        t_protect();
        t_ident();
        t_hs();
        final_report();
    end
endmodule : testbench
